// ---- serial_cfg_pkg.sv ----
// Package for the serial configuration and supervision block.
// Assumes a 40 MHz system clock; all times below are turned into cycle counts here.
package serial_cfg_pkg;

    localparam int unsigned CLK_HZ = 40000000;

    // Telegram gap watchdog: seconds, 0 means supervision off.
    localparam logic [15:0] GAP_OFF = 16'h0000;
    localparam logic [15:0] GAP_MAX_S = 16'hFFFE;
    localparam logic [15:0] GAP_RESET = GAP_OFF;
    localparam int unsigned SEC_CYCLES = CLK_HZ;

    // Inter-character timeout in milliseconds.
    localparam logic [10:0] ICT_MIN_MS = 11'h00A;
    localparam logic [10:0] ICT_MAX_MS = 11'h7D0;
    localparam logic [10:0] ICT_RESET_MS = 11'h064;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

    // Pulse input frequency limits in Hz, shortest and longest period in cycles.
    localparam int unsigned PULSE_FMAX_HZ = 67600;
    localparam int unsigned PULSE_FMIN_HZ = 5;
    localparam int unsigned PULSE_MIN_PER = CLK_HZ / PULSE_FMAX_HZ;
    localparam int unsigned PULSE_MAX_PER = CLK_HZ / PULSE_FMIN_HZ;

    // Thermal limits.
    localparam logic [7:0] LOAD_CUTOUT_PCT = 8'h64;
    localparam logic [7:0] TEMP_CUTOUT_C = 8'h5F;
    localparam logic [7:0] TEMP_RESUME_C = 8'h46;

    // Digital input count.
    localparam int unsigned DIN_COUNT = 5;

    // Point groups and address range for override release.
    localparam logic [7:0] POINT_ADDR_LAST = 8'hFF;

    typedef enum logic [2:0] {
        GRP_ANALOG_OUT = 3'h0,
        GRP_BINARY_OUT = 3'h1,
        GRP_INT_FLOAT = 3'h2,
        GRP_INT_INTEGER = 3'h3,
        GRP_INT_BYTE = 3'h4
    } point_group_t;

    typedef enum logic [1:0] {
        PROTO_NATIVE = 2'h0,
        PROTO_AUTOMATION = 2'h1,
        PROTO_RTU = 2'h2
    } protocol_t;
    localparam protocol_t PROTO_RESET = PROTO_NATIVE;

    typedef enum logic [1:0] {
        FRAME_EVEN_1 = 2'h0,
        FRAME_ODD_1 = 2'h1,
        FRAME_NONE_1 = 2'h2,
        FRAME_NONE_2 = 2'h3
    } frame_sel_t;
    localparam frame_sel_t FRAME_RESET = FRAME_NONE_1;

    // Decoded line framing handed to the serial engine.
    typedef struct packed {
        logic parity_en;
        logic parity_odd;
        logic two_stop;
    } frame_fmt_t;

    // One override release request.
    typedef struct packed {
        point_group_t group;
        logic [7:0] addr;
    } release_req_t;

endpackage : serial_cfg_pkg

// ---- pulse_counter.sv ----
// Counter-stop pulse counter with period qualification.
// Assumes pulse_i is already synchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
module pulse_counter #(
    parameter int unsigned WIDTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic pulse_i,
    output logic [WIDTH-1:0] count_o
);
    import serial_cfg_pkg::*;

    // A narrow count would wrap within a fraction of a second at the top rate.
    if (WIDTH < 8) begin : g_chk
        $error("pulse_counter WIDTH too small");
    end

    logic prev_q, prev_d;
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic [23:0] per_q, per_d;

    // Counts a rising edge only when its period is no shorter than the shortest supported period.
    // Edges faster than the top rate are glitches; the very first edge always passes the period check.
    always_comb begin
        prev_d = pulse_i;
        cnt_d = cnt_q;
        per_d = (per_q == 24'hFFFFFF) ? per_q : per_q + 24'h000001;
        if (pulse_i && !prev_q) begin
            per_d = 24'h000000;
            if (run_i && per_q >= 24'(PULSE_MIN_PER)) begin
                cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
        if (restart_i) begin
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            cnt_q <= '0;
            per_q <= 24'hFFFFFF;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
        end
    end

    assign count_o = cnt_q;

endmodule : pulse_counter
`default_nettype wire

// ---- serial_comm_config.sv ----
// Serial communication configuration and supervision for a motor drive.
// Assumes all inputs synchronous to clk_sys_i and one-cycle event strobes from the serial engine.
// Behaviour
// - The telegram gap is programmable in seconds from 1 to 65534, with 0 meaning off, which is the reset value.
// - When the gap is exceeded under the automation protocol the block treats the link as stopped and releases every overridden point.
// - Release runs analogue out, binary out, float, integer, then byte points, each from address 0 to 255.
// - Protocol code 0 is the native protocol (default), 1 the automation protocol, 2 RTU.
// - Framing 0 is even/1 stop, 1 odd/1 stop, 2 none/1 stop (default), 3 none/2 stops.
// - The selected parity must match the master's, so the decoded framing is handed on unchanged.
// - The five digital inputs read as bits, first input leftmost, 1 meaning connected.
// - In counter-stop mode pulses from 5 Hz to 67.6 kHz are counted and the count clears on restart.
// - Motor and converter thermal loads trip a cut-out when either reaches 100 percent.
// - Inverter temperature trips between 90 and 100 C and resumes only at 70 C or below.
// - The master may write a bus feedback value that joins the feedback path.
// - The scaled frequency readout is output frequency times the display scale factor.
// - An RTU message ends when no character arrives within the 10 to 2000 ms timeout, 100 ms by default.
`timescale 1ns/10ps
`default_nettype none
module serial_comm_config #(
    parameter int unsigned SEC_CYC = serial_cfg_pkg::SEC_CYCLES,
    parameter int unsigned MS_CYC = serial_cfg_pkg::MS_CYCLES,
    parameter int unsigned FREQ_W = 16,
    parameter int unsigned SCALE_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Configuration.
    input wire logic cfg_we_i,
    input wire logic [15:0] override_release_time_i,
    input wire serial_cfg_pkg::protocol_t protocol_i,
    input wire serial_cfg_pkg::frame_sel_t frame_sel_i,
    input wire logic [10:0] rtu_intercharacter_timeout_i,
    // Serial engine events.
    input wire logic telegram_ok_i,
    input wire logic rtu_char_i,
    output logic [15:0] override_release_time_o,
    output serial_cfg_pkg::protocol_t protocol_o,
    output serial_cfg_pkg::frame_fmt_t frame_fmt_o,
    output logic [10:0] rtu_intercharacter_timeout_o,
    output logic comm_stopped_o,
    output logic release_valid_o,
    output serial_cfg_pkg::release_req_t release_o,
    output logic rtu_msg_end_o,
    // Readouts.
    input wire logic [4:0] din_i,
    output logic [4:0] din_status_o,
    input wire logic count_run_i,
    input wire logic count_restart_i,
    input wire logic pulse_i,
    output logic [31:0] pulse_count_o,
    input wire logic [7:0] motor_load_i,
    input wire logic [7:0] converter_thermal_load_i,
    output logic thermal_cutout_o,
    input wire logic [7:0] inverter_temp_i,
    output logic temp_cutout_o,
    input wire logic bus_feedback_we_i,
    input wire logic [15:0] bus_feedback_value_i,
    output logic [15:0] bus_feedback_value_o,
    input wire logic [FREQ_W-1:0] out_freq_i,
    input wire logic [SCALE_W-1:0] freq_scale_i,
    output logic [FREQ_W+SCALE_W-1:0] freq_scaled_o
);
    import serial_cfg_pkg::*;

    // Refuse settings that the 26-bit second tick or the 16-bit millisecond tick cannot hold.
    if (SEC_CYC < 1 || SEC_CYC > 67108864 || MS_CYC < 1 || MS_CYC > 65536 || FREQ_W < 1 || SCALE_W < 1) begin : g_chk
        $error("serial_comm_config parameters out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WATCH = 2'h1,
        ST_RELEASE = 2'h2
    } gap_state_t;

    // Configuration state.
    logic [15:0] gap_q, gap_d;
    protocol_t proto_q, proto_d;
    frame_sel_t frame_q, frame_d;
    logic [10:0] ict_q, ict_d;
    logic [15:0] fb_q, fb_d;

    // Configuration writes; out-of-range values are ignored so the old setting stays.
    always_comb begin
        gap_d = gap_q;
        proto_d = proto_q;
        frame_d = frame_q;
        ict_d = ict_q;
        fb_d = fb_q;
        if (cfg_we_i) begin
            if (override_release_time_i <= GAP_MAX_S) begin
                gap_d = override_release_time_i;
            end
            if (protocol_i == PROTO_NATIVE || protocol_i == PROTO_AUTOMATION || protocol_i == PROTO_RTU) begin
                proto_d = protocol_i;
            end
            frame_d = frame_sel_i;
            if (rtu_intercharacter_timeout_i >= ICT_MIN_MS && rtu_intercharacter_timeout_i <= ICT_MAX_MS) begin
                ict_d = rtu_intercharacter_timeout_i;
            end
        end
        if (bus_feedback_we_i) begin
            fb_d = bus_feedback_value_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gap_q <= GAP_RESET;
            proto_q <= PROTO_RESET;
            frame_q <= FRAME_RESET;
            ict_q <= ICT_RESET_MS;
            fb_q <= 16'h0000;
        end else begin
            gap_q <= gap_d;
            proto_q <= proto_d;
            frame_q <= frame_d;
            ict_q <= ict_d;
            fb_q <= fb_d;
        end
    end

    // Framing decode; the parity here must equal the master's or every frame fails.
    frame_fmt_t fmt_d, fmt_q;
    always_comb begin
        case (frame_q)
            FRAME_EVEN_1: fmt_d = '{parity_en: 1'b1, parity_odd: 1'b0, two_stop: 1'b0};
            FRAME_ODD_1: fmt_d = '{parity_en: 1'b1, parity_odd: 1'b1, two_stop: 1'b0};
            FRAME_NONE_1: fmt_d = '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b0};
            FRAME_NONE_2: fmt_d = '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b1};
            default: fmt_d = '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b0};
        endcase
    end

    // Gap watchdog: one-second tick plus a seconds counter, then a release walk.
    gap_state_t st_q, st_d;
    logic [25:0] tick_q, tick_d;
    logic [15:0] sec_q, sec_d;
    release_req_t rel_q, rel_d;
    logic stop_q, stop_d;
    // Release valid is held in its own flop so the port never comes from a state decode.
    logic relv_q, relv_d;
    logic auto_mode;
    assign auto_mode = (proto_q == PROTO_AUTOMATION);

    always_comb begin
        st_d = st_q;
        tick_d = tick_q;
        sec_d = sec_q;
        rel_d = rel_q;
        stop_d = stop_q;
        case (st_q)
            ST_IDLE: begin
                tick_d = 26'h0000000;
                sec_d = 16'h0000;
                if (gap_q != GAP_OFF && auto_mode) begin
                    st_d = ST_WATCH;
                end
            end
            ST_WATCH: begin
                if (tick_q == 26'(SEC_CYC - 1)) begin
                    tick_d = 26'h0000000;
                    sec_d = sec_q + 16'h0001;
                end else begin
                    tick_d = tick_q + 26'h0000001;
                end
                if (gap_q == GAP_OFF || !auto_mode) begin
                    st_d = ST_IDLE;
                end else if (sec_q >= gap_q) begin
                    stop_d = 1'b1;
                    rel_d = '{group: GRP_ANALOG_OUT, addr: 8'h00};
                    st_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (rel_q.addr != POINT_ADDR_LAST) begin
                    rel_d.addr = rel_q.addr + 8'h01;
                end else if (rel_q.group != GRP_INT_BYTE) begin
                    rel_d.addr = 8'h00;
                    rel_d.group = point_group_t'(rel_q.group + 3'h1);
                end else begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (telegram_ok_i) begin
            stop_d = 1'b0;
            if (st_q == ST_WATCH) begin
                tick_d = 26'h0000000;
                sec_d = 16'h0000;
            end
        end
        relv_d = (st_d == ST_RELEASE);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            tick_q <= 26'h0000000;
            sec_q <= 16'h0000;
            rel_q <= '{group: GRP_ANALOG_OUT, addr: 8'h00};
            stop_q <= 1'b0;
            relv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tick_q <= tick_d;
            sec_q <= sec_d;
            rel_q <= rel_d;
            stop_q <= stop_d;
            relv_q <= relv_d;
        end
    end

    // RTU end-of-message: millisecond tick and silence counter, pulse once per message.
    logic [15:0] mtick_q, mtick_d;
    logic [10:0] ms_q, ms_d;
    logic armed_q, armed_d;
    logic end_q, end_d;
    always_comb begin
        mtick_d = mtick_q;
        ms_d = ms_q;
        armed_d = armed_q;
        end_d = 1'b0;
        if (rtu_char_i) begin
            mtick_d = 16'h0000;
            ms_d = 11'h000;
            armed_d = (proto_q == PROTO_RTU);
        end else if (armed_q) begin
            if (mtick_q == 16'(MS_CYC - 1)) begin
                mtick_d = 16'h0000;
                ms_d = ms_q + 11'h001;
            end else begin
                mtick_d = mtick_q + 16'h0001;
            end
            if (ms_q >= ict_q) begin
                end_d = 1'b1;
                armed_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mtick_q <= 16'h0000;
            ms_q <= 11'h000;
            armed_q <= 1'b0;
            end_q <= 1'b0;
        end else begin
            mtick_q <= mtick_d;
            ms_q <= ms_d;
            armed_q <= armed_d;
            end_q <= end_d;
        end
    end

    // Readouts and thermal supervision, all registered.
    logic [4:0] din_d, din_q;
    logic tcut_d, tcut_q, icut_d, icut_q;
    logic [FREQ_W+SCALE_W-1:0] fs_d, fs_q;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            din_d[4-i] = din_i[i];
        end
        tcut_d = (motor_load_i >= LOAD_CUTOUT_PCT) || (converter_thermal_load_i >= LOAD_CUTOUT_PCT);
        icut_d = icut_q;
        if (inverter_temp_i >= TEMP_CUTOUT_C) begin
            icut_d = 1'b1;
        end else if (inverter_temp_i <= TEMP_RESUME_C) begin
            icut_d = 1'b0;
        end
        fs_d = out_freq_i * freq_scale_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            din_q <= 5'h00;
            tcut_q <= 1'b0;
            icut_q <= 1'b0;
            fs_q <= '0;
            fmt_q <= '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b0};
        end else begin
            din_q <= din_d;
            tcut_q <= tcut_d;
            icut_q <= icut_d;
            fs_q <= fs_d;
            fmt_q <= fmt_d;
        end
    end

    pulse_counter #(
        .WIDTH(32)
    ) u_pulse_counter (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(count_run_i),
        .restart_i(count_restart_i),
        .pulse_i(pulse_i),
        .count_o(pulse_count_o)
    );

    assign frame_fmt_o = fmt_q;
    assign override_release_time_o = gap_q;
    assign protocol_o = proto_q;
    assign rtu_intercharacter_timeout_o = ict_q;
    assign comm_stopped_o = stop_q;
    assign release_valid_o = relv_q;
    assign release_o = rel_q;
    assign rtu_msg_end_o = end_q;
    assign din_status_o = din_q;
    assign thermal_cutout_o = tcut_q;
    assign temp_cutout_o = icut_q;
    assign bus_feedback_value_o = fb_q;
    assign freq_scaled_o = fs_q;

endmodule : serial_comm_config
`default_nettype wire

// ---- serial_comm_config_asserts.sv ----
// Port checks for the serial configuration block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module serial_comm_config_asserts
import serial_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cfg_we_i,
    input wire logic [15:0] override_release_time_i,
    input wire protocol_t protocol_i,
    input wire frame_sel_t frame_sel_i,
    input wire logic [10:0] rtu_intercharacter_timeout_i,
    input wire logic telegram_ok_i,
    input wire logic count_restart_i,
    input wire logic [4:0] din_i,
    input wire logic [15:0] override_release_time_o,
    input wire protocol_t protocol_o,
    input wire frame_fmt_t frame_fmt_o,
    input wire logic [10:0] rtu_intercharacter_timeout_o,
    input wire logic comm_stopped_o,
    input wire logic release_valid_o,
    input wire release_req_t release_o,
    input wire logic [4:0] din_status_o,
    input wire logic [31:0] pulse_count_o
);
    logic [4:0] din_rev;

    // All checks share the system clock and stay quiet in reset.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Input order reversed, since the first input sits leftmost.
    always_comb din_rev = {din_i[0], din_i[1], din_i[2], din_i[3], din_i[4]};

    // Expected line framing for a selector code.
    function automatic frame_fmt_t dec(input logic [1:0] s);
        return '{!s[1], s == 2'h1, s == 2'h3};
    endfunction : dec

    // Configuration loads, refusals and decode latency.
    property p_proto; cfg_we_i && protocol_i != 2'h3 |=> protocol_o == $past(protocol_i); endproperty
    a_proto: assert property (p_proto) else $error("protocol not loaded");
    property p_gap; cfg_we_i && override_release_time_i == 16'hFFFF |=> $stable(override_release_time_o); endproperty
    a_gap: assert property (p_gap) else $error("gap code 65535 taken");
    property p_ict; cfg_we_i && rtu_intercharacter_timeout_i >= ICT_MIN_MS && rtu_intercharacter_timeout_i <= ICT_MAX_MS
        |=> rtu_intercharacter_timeout_o == $past(rtu_intercharacter_timeout_i); endproperty
    a_ict: assert property (p_ict) else $error("char timeout not loaded");
    property p_frame; cfg_we_i |-> ##2 frame_fmt_o == dec($past(frame_sel_i, 2)); endproperty
    a_frame: assert property (p_frame) else $error("framing decode wrong");

    // The release walk starts at the first point and steps one point a cycle.
    property p_rel0; $rose(release_valid_o) |-> release_o == 11'h000; endproperty
    a_rel0: assert property (p_rel0) else $error("walk start wrong");
    property p_step; release_valid_o && release_o != 11'h4FF |=> release_valid_o && release_o == $past(release_o) + 11'h001;
    endproperty
    a_step: assert property (p_step) else $error("walk step wrong");
    property p_end; release_valid_o && release_o == 11'h4FF |=> !release_valid_o; endproperty
    a_end: assert property (p_end) else $error("walk did not stop");
    property p_tel; telegram_ok_i |=> !comm_stopped_o; endproperty
    a_tel: assert property (p_tel) else $error("stop flag kept after telegram");

    // Readouts.
    property p_cnt; count_restart_i |=> pulse_count_o == 32'h0000_0000; endproperty
    a_cnt: assert property (p_cnt) else $error("count not cleared");
    property p_din; !$past(rst_i) |-> din_status_o == $past(din_rev); endproperty
    a_din: assert property (p_din) else $error("input status wrong");
endmodule : serial_comm_config_asserts

bind serial_comm_config serial_comm_config_asserts serial_comm_config_asserts_inst (.*);
`default_nettype wire

// ---- serial_master_model.sv ----
// Behavioural serial master feeding the block's event inputs.
// Assumes one request pulse from the bench per telegram or character.
`timescale 1ns/10ps
`default_nettype none
module serial_master_model
import serial_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic send_tel_i,
    input wire logic send_char_i,
    input wire frame_fmt_t dev_fmt_i,
    input wire frame_fmt_t master_fmt_i,
    output logic telegram_ok_o,
    output logic rtu_char_o
);
    logic tel_d;
    logic char_d;

    // framing must agree
    // A frame sent with other framing arrives garbled, so nothing is reported.
    always_comb begin
        tel_d = send_tel_i && (dev_fmt_i == master_fmt_i);
        char_d = send_char_i && (dev_fmt_i == master_fmt_i);
    end

    // One-cycle event pulses, as the serial engine gives them.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            telegram_ok_o <= 1'b0;
            rtu_char_o <= 1'b0;
        end else begin
            telegram_ok_o <= tel_d;
            rtu_char_o <= char_d;
        end
    end
endmodule : serial_master_model
`default_nettype wire

// ---- drive_serial_comm_config_test.sv ----
// Self-checking bench for the serial configuration block.
// Assumes the master model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module drive_serial_comm_config_test;
    import serial_cfg_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, cfg_we_i = 1'b0, count_run_i = 1'b0, count_restart_i = 1'b0, pulse_i = 1'b0;
    logic bus_feedback_we_i = 1'b0, send_tel = 1'b0, send_char = 1'b0, seen;
    logic [15:0] override_release_time_i = 16'h0, bus_feedback_value_i = 16'h0, out_freq_i = 16'h0, freq_scale_i = 16'h0;
    protocol_t protocol_i = PROTO_NATIVE;
    frame_sel_t frame_sel_i = FRAME_NONE_1;
    logic [10:0] rtu_intercharacter_timeout_i = 11'h064;
    logic [4:0] din_i = 5'h00;
    logic [7:0] motor_load_i = 8'h0, converter_thermal_load_i = 8'h0, inverter_temp_i = 8'h0;
    frame_fmt_t master_fmt = 3'h0;
    logic telegram_ok_i, rtu_char_i, comm_stopped_o, release_valid_o, rtu_msg_end_o, thermal_cutout_o, temp_cutout_o;
    logic [15:0] override_release_time_o, bus_feedback_value_o;
    protocol_t protocol_o;
    frame_fmt_t frame_fmt_o;
    logic [10:0] rtu_intercharacter_timeout_o;
    release_req_t release_o;
    logic [4:0] din_status_o;
    logic [31:0] pulse_count_o, freq_scaled_o;
    logic [2:0] ftab [4] = '{3'h4, 3'h6, 3'h0, 3'h1};
    logic [7:0] temps [6] = '{8'h5E, 8'h5F, 8'h50, 8'h47, 8'h46, 8'h4B};
    int n, cyc = 0, checked = 0, bad_count = 0;

    // Short second and millisecond so the watchdog and RTU timing fit the run.
    serial_comm_config #(.SEC_CYC(10), .MS_CYC(4)) serial_comm_config_inst (.*);
    serial_master_model serial_master_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .send_tel_i(send_tel),
        .send_char_i(send_char), .dev_fmt_i(frame_fmt_o), .master_fmt_i(master_fmt), .telegram_ok_o(telegram_ok_i),
        .rtu_char_o(rtu_char_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // Hang guard; the tests take about 3600 cycles.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            test_done();
        end
    end

    // Inputs always move 2 ns after the rising edge.
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys_i);
        #2;
    endtask : tick

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked = checked + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    // One configuration write, then wait out the framing decode.
    task automatic cfg(input logic [15:0] g, input logic [1:0] p, input logic [1:0] f, input logic [10:0] t);
        override_release_time_i = g;
        protocol_i = protocol_t'(p);
        frame_sel_i = frame_sel_t'(f);
        rtu_intercharacter_timeout_i = t;
        cfg_we_i = 1'b1;
        tick(1);
        cfg_we_i = 1'b0;
        tick(2);
    endtask : cfg

    // Ask the master for a telegram (1) or an RTU character (0).
    task automatic pulse(input logic t);
        send_tel = t;
        send_char = !t;
        tick(1);
        send_tel = 1'b0;
        send_char = 1'b0;
    endtask : pulse

    task automatic test_done();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // Test sequence.
    initial begin
        tick(8);
        rst_i = 1'b0;
        check({override_release_time_o, protocol_o, rtu_intercharacter_timeout_o, frame_fmt_o}, 32'h320);
        check({comm_stopped_o, release_valid_o, rtu_msg_end_o}, 3'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            cfg(16'hFFFE, i[1:0], i[1:0], 11'h7D0);
            check(protocol_o, (i == 3) ? 2'h2 : i[1:0]);
            check(frame_fmt_o, ftab[i]);
        end
        cfg(16'hFFFF, 2'h0, 2'h2, 11'h009);
        check({override_release_time_o, rtu_intercharacter_timeout_o}, 27'h7FFF7D0);
        cfg(16'h0001, 2'h0, 2'h2, 11'h00A);
        check({override_release_time_o, rtu_intercharacter_timeout_o}, 27'h000080A);
        $display("config test done");
        cfg(16'h0002, 2'h1, 2'h2, 11'h064);
        repeat (3) begin
            pulse(1'b1);
            tick(12);
            check(release_valid_o, 1'b0);
        end
        pulse(1'b1);
        n = 0;
        while (release_valid_o !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n >= 19 && n <= 25, 1'b1);
        check(comm_stopped_o, 1'b1);
        for (int k = 0; k < 1280; k++) begin
            check({release_valid_o, release_o}, {1'b1, k[10:0]});
            send_tel = (k == 100);
            tick(1);
        end
        check({release_valid_o, comm_stopped_o}, 2'h0);
        cfg(16'h0000, 2'h1, 2'h2, 11'h064);
        seen = 1'b0;
        repeat (60) begin
            tick(1);
            seen = seen | release_valid_o;
        end
        check(seen, 1'b0);
        $display("watchdog test done");
        cfg(16'h0000, 2'h2, 2'h2, 11'h00A);
        pulse(1'b0);
        tick(30);
        pulse(1'b0);
        n = 0;
        while (rtu_msg_end_o !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n >= 40 && n <= 46, 1'b1);
        master_fmt = 3'h4;
        pulse(1'b0);
        seen = 1'b0;
        repeat (60) begin
            tick(1);
            seen = seen | rtu_msg_end_o;
        end
        check(seen, 1'b0);
        $display("rtu test done");
        din_i = 5'h01;
        tick(2);
        check(din_status_o, 5'h10);
        din_i = 5'h16;
        tick(2);
        check(din_status_o, 5'h0D);
        motor_load_i = 8'h63;
        converter_thermal_load_i = 8'h63;
        tick(2);
        check(thermal_cutout_o, 1'b0);
        motor_load_i = 8'h64;
        tick(2);
        check(thermal_cutout_o, 1'b1);
        motor_load_i = 8'h00;
        converter_thermal_load_i = 8'h64;
        tick(2);
        check(thermal_cutout_o, 1'b1);
        for (int i = 0; i < 6; i++) begin
            inverter_temp_i = temps[i];
            tick(2);
            check(temp_cutout_o, 6'h0E >> i & 1);
        end
        bus_feedback_value_i = 16'hA5C3;
        bus_feedback_we_i = 1'b1;
        tick(1);
        bus_feedback_we_i = 1'b0;
        bus_feedback_value_i = 16'h1234;
        out_freq_i = 16'h012C;
        freq_scale_i = 16'h0007;
        tick(2);
        check(bus_feedback_value_o, 16'hA5C3);
        check(freq_scaled_o, 32'h0000_0834);
        $display("readout test done");
        count_run_i = 1'b1;
        count_restart_i = 1'b1;
        tick(1);
        count_restart_i = 1'b0;
        tick(1);
        check(pulse_count_o, 32'h0);
        for (int i = 0; i < 5; i++) begin
            pulse_i = 1'b1;
            tick(2);
            pulse_i = 1'b0;
            tick(i < 3 ? 598 : 98);
        end
        check(pulse_count_o, 32'h4);
        count_restart_i = 1'b1;
        tick(1);
        count_restart_i = 1'b0;
        tick(1);
        check(pulse_count_o, 32'h0);
        $display("pulse test done");
        test_done();
    end
endmodule : drive_serial_comm_config_test
`default_nettype wire
